// [rtl/tes_defines.vh]
`ifndef TES_DEFINES_VH
`define TES_DEFINES_VH

// Register indices; the byte address is four times the index.
`define TES_IDX_EDGE_LENGTH    14'h0511
`define TES_IDX_RESIDUAL_AMPL  14'h0512
`define TES_IDX_EDGE_TYPE      14'h0513
`define TES_IDX_EDGE_STYLE     14'h0514
`define TES_IDX_STATUS         14'h0518

// Edge length fields.
`define TES_LEN_DOUBLE_BIT     7
`define TES_LEN_COUNT_HI       4
`define TES_LEN_COUNT_LO       0
`define TES_LEN_WRITE_MASK     8'h9F

// Edge style fields (style configuration of each edge).
`define TES_STY_WRITE_MASK     8'h77

// Reset values.
`define TES_RST_EDGE_LENGTH    8'h08
`define TES_RST_RESIDUAL_AMPL  8'h00
`define TES_RST_EDGE_TYPE      8'h11
`define TES_RST_EDGE_STYLE     8'h00

// Edge shape codes.
`define TES_SHAPE_LIN1         4'h1
`define TES_SHAPE_LIN2         4'h2
`define TES_SHAPE_LIN3         4'h3
`define TES_SHAPE_LUT_FIXED    4'h4
`define TES_SHAPE_LUT_CORR     4'h5
`define TES_SHAPE_LUT_ADAPT    4'h6

// Amplitude codes.
`define TES_AMPL_FULL          8'hFF
`define TES_SUPPLY_NOMINAL     8'h80

// Lookup tables, nine points each, entry 0 in the low byte.
`define TES_LUT0 72'hFF_E0_C0_A0_80_60_40_20_00
`define TES_LUT1 72'hFF_D0_A0_78_50_30_18_08_00
`define TES_LUT2 72'hFF_F8_E8_D0_B0_88_60_30_00
`define TES_LUT3 72'hFF_F8_E0_B8_80_48_20_08_00

`endif

// [rtl/tes_blend.v]
`timescale 1ns/1ps
`default_nettype none
module tes_blend (
	// Edge end points.
	input  wire [7:0] start_in,
	input  wire [7:0] end_in,
	// Shaped progress, 0 at start and 0xFF at end.
	input  wire [7:0] frac_in,
	// Mixed amplitude.
	output wire [7:0] ampl_out
);
	wire [8:0]  weight;
	wire [8:0]  inv_weight;
	wire [17:0] mix;

	// Full progress maps to a weight of 256 so the end level is reached exactly.
	assign weight     = (frac_in == 8'hFF) ? 9'h100 : {1'b0, frac_in};
	assign inv_weight = 9'h100 - weight;
	assign mix        = start_in * inv_weight + end_in * weight;
	assign ampl_out   = mix[15:8];
endmodule // tes_blend
`default_nettype wire

// [rtl/tes_curve.v]
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.vh"
module tes_curve (
	// Linear progress through the edge.
	input  wire [7:0] prog_in,
	// Shape code and style configuration of this edge.
	input  wire [3:0] shape_in,
	input  wire [2:0] style_in,
	// Power-amplifier supply level.
	input  wire [7:0] pa_supply_voltage_in,
	// Shaped progress.
	output reg  [7:0] frac_out
);
	reg  [71:0]        lut;
	reg  [7:0]         y0;
	reg  [7:0]         y1;
	reg  [8:0]         knee;
	reg  [16:0]        seg;
	reg  [13:0]        step;
	reg  [7:0]         lut_s;
	reg  [15:0]        bowp;
	reg signed [8:0]   dev;
	reg signed [17:0]  bend;
	reg signed [17:0]  adj;
	wire [3:0]         idx;

	assign idx = {1'b0, prog_in[7:5]};

	// Curve selection; unknown codes fall back to one straight ramp.
	always @* begin
		lut   = `TES_LUT0;
		y0    = 8'h00;
		y1    = 8'h00;
		knee  = 9'h000;
		seg   = 17'h00000;
		step  = 14'h0000;
		lut_s = 8'h00;
		bowp  = 16'h0000;
		dev   = 9'sh000;
		bend  = 18'sh00000;
		adj   = 18'sh00000;
		frac_out = prog_in;
		case (style_in[1:0])
			2'h0: lut = `TES_LUT0;
			2'h1: lut = `TES_LUT1;
			2'h2: lut = `TES_LUT2;
			default: lut = `TES_LUT3;
		endcase
		y0    = lut[idx*8 +: 8];
		y1    = lut[(idx+4'h1)*8 +: 8];
		step  = (y1 - y0) * prog_in[4:0];
		lut_s = y0 + step[12:5];
		case (shape_in)
			`TES_SHAPE_LIN1: frac_out = prog_in;
			`TES_SHAPE_LIN2: begin
				// The time constant lifts the knee at mid edge.
				knee = 9'h080 + {2'b00, style_in, 4'h0};
				if (prog_in < 8'h80) begin
					seg = prog_in * knee;
					frac_out = seg[14:7];
				end else begin
					seg = {9'h000, knee[7:0]} + (((prog_in - 8'h80) * (9'h0FF - knee)) >> 7);
					frac_out = (seg > 17'h000FF) ? 8'hFF : seg[7:0];
				end
			end
			`TES_SHAPE_LIN3: begin
				// Quarter, half, quarter split so every slope divides by a power of two.
				knee = 9'h040 + {3'b000, style_in, 3'h0};
				if (prog_in < 8'h40) begin
					seg = prog_in * knee;
					frac_out = seg[13:6];
				end else if (prog_in < 8'hC0) begin
					seg = {9'h000, knee[7:0]} + (((prog_in - 8'h40) * (9'h0FF - (knee << 1))) >> 7);
					frac_out = seg[7:0];
				end else begin
					seg = {9'h000, 8'hFF - knee[7:0]} + (((prog_in - 8'hC0) * knee) >> 6);
					frac_out = (seg > 17'h000FF) ? 8'hFF : seg[7:0];
				end
			end
			`TES_SHAPE_LUT_FIXED: frac_out = lut_s;
			`TES_SHAPE_LUT_CORR, `TES_SHAPE_LUT_ADAPT: begin
				// A low supply lifts the middle of the curve, a high one lowers it.
				bowp = lut_s * (8'hFF - lut_s);
				dev  = $signed({1'b0, pa_supply_voltage_in}) - $signed({1'b0, `TES_SUPPLY_NOMINAL});
				bend = $signed({1'b0, bowp[15:8]}) * dev;
				adj  = $signed({10'h000, lut_s}) - (bend >>> 7);
				if (adj < 18'sh00000)
					frac_out = 8'h00;
				else if (adj > 18'sh000FF)
					frac_out = 8'hFF;
				else
					frac_out = adj[7:0];
			end
			default: frac_out = prog_in;
		endcase
		if (prog_in == 8'hFF)
			frac_out = 8'hFF;
	end
endmodule // tes_curve
`default_nettype wire

// [rtl/tes_top.v]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.vh"
module tes_top (
	// Clock, reset and clock enable.
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire        en_in,
	// Register port.
	input  wire [15:0] reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire        reg_write_in,
	input  wire        reg_read_in,
	output reg  [7:0]  reg_rdata_out,
	// Modulation request and supply level.
	input  wire        modulate_in,
	input  wire [7:0]  pa_supply_voltage_in,
	// Carrier amplitude towards the transmitter.
	output reg  [7:0]  carrier_ampl_out,
	output reg         edge_busy_out,
	output reg         edge_falling_out
);
	// Shaper states. One bit is enough: either an edge runs or the output rests on its target.
	localparam [0:0] ST_IDLE = 1'b0;
	localparam [0:0] ST_EDGE = 1'b1;

	// Configuration registers. They stay writable while an edge runs and are read live,
	// so a rewrite of the state count or the doubling bit mid-edge lengthens or cuts
	// the running edge; software that wants clean edges writes them between edges.
	reg  [7:0] edge_length_q;
	reg  [7:0] residual_ampl_q;
	reg  [7:0] edge_type_q;
	reg  [7:0] edge_style_q;

	// Shaper state. start_q and end_q are the two levels of the running edge, step_q the
	// state number from one up to the state count, hold_q marks the second cycle of a doubled state.
	reg        state_q;
	reg        state_d;
	reg        mod_q;
	reg        mod_d;
	reg  [7:0] start_q;
	reg  [7:0] start_d;
	reg  [7:0] end_q;
	reg  [7:0] end_d;
	reg  [4:0] step_q;
	reg  [4:0] step_d;
	reg        hold_q;
	reg        hold_d;
	reg  [7:0] ampl_d;
	reg        busy_d;
	reg        falling_d;

	// Register port decode.
	wire [13:0] reg_idx;
	wire        addr_ok;
	wire [7:0]  status_word;
	reg  [7:0]  rdata_d;

	// Edge arithmetic. All of it is combinational from registered values and the supply input, so the level of a
	// state is ready in the cycle the state number changes and shows on the carrier at the next edge.
	wire [4:0]  state_count;
	wire        double_time;
	wire [3:0]  shape_code;
	wire [2:0]  style_code;
	wire [7:0]  target_ampl;
	wire [12:0] prog_num;
	wire [12:0] prog_den;
	wire [12:0] prog_quot;
	wire [7:0]  prog;
	wire [7:0]  frac;
	wire [7:0]  blend_ampl;
	wire        last_hold;
	wire        keep_monotonic;
	reg  [7:0]  shaped_ampl;

	assign reg_idx = reg_addr_in[15:2];
	assign addr_ok = (reg_addr_in[1:0] == 2'b00);

	// Status word: busy, direction, applied modulation level and the current state number.
	// Software can poll it to see how far an edge has got; it is read-only.
	assign status_word = {edge_busy_out, edge_falling_out, mod_q, step_q};

	// Register writes. Reserved bits are masked so they always read back as zero, which is
	// cheaper than a separate read mask and keeps stray bits away from the shaper. Writes to
	// the status index or to unmapped or misaligned addresses are dropped. A write lands at
	// the edge that samples the strobe, so the shaper uses the new value one cycle later.
	// Each entry has its own strobe, decoded in one loop from the table of indices below.
	localparam [55:0] CFG_IDX = {`TES_IDX_EDGE_STYLE, `TES_IDX_EDGE_TYPE,
		`TES_IDX_RESIDUAL_AMPL, `TES_IDX_EDGE_LENGTH};
	wire [3:0] cfg_wr;
	genvar     g;

	generate
		for (g = 0; g < 4; g = g + 1) begin : g_cfg_wr
			assign cfg_wr[g] = en_in && reg_write_in && addr_ok && (reg_idx == CFG_IDX[g*14 +: 14]);
		end
	endgenerate

	// Edge length: bit 7 doubles every state, bits 4:0 count the states.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			edge_length_q <= `TES_RST_EDGE_LENGTH;
		else if (cfg_wr[0])
			edge_length_q <= reg_wdata_in & `TES_LEN_WRITE_MASK;
	end

	// Residual level held while modulating.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			residual_ampl_q <= `TES_RST_RESIDUAL_AMPL;
		else if (cfg_wr[1])
			residual_ampl_q <= reg_wdata_in;
	end

	// Shape codes, falling edge in the upper nibble and rising edge in the lower one.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			edge_type_q <= `TES_RST_EDGE_TYPE;
		else if (cfg_wr[2])
			edge_type_q <= reg_wdata_in;
	end

	// Style configuration of each edge: time constant or table number.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			edge_style_q <= `TES_RST_EDGE_STYLE;
		else if (cfg_wr[3])
			edge_style_q <= reg_wdata_in & `TES_STY_WRITE_MASK;
	end

	// Read mux. Unmapped or misaligned addresses read as zero, and so does every cycle
	// without a read strobe, which lets the answer be told apart from idle bus time.
	always @* begin
		rdata_d = 8'h00;
		if (reg_read_in && addr_ok) begin
			case (reg_idx)
				`TES_IDX_EDGE_LENGTH:   rdata_d = edge_length_q;
				`TES_IDX_RESIDUAL_AMPL: rdata_d = residual_ampl_q;
				`TES_IDX_EDGE_TYPE:     rdata_d = edge_type_q;
				`TES_IDX_EDGE_STYLE:    rdata_d = edge_style_q;
				`TES_IDX_STATUS:        rdata_d = status_word;
				default:                rdata_d = 8'h00;
			endcase
		end
	end

	// Read data stands for exactly the cycle after the strobe. Outside a read the register
	// is cleared, so a stale value is never taken for an answer; with the clock enable low
	// the answer is held together with everything else.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			reg_rdata_out <= 8'h00;
		else if (en_in)
			reg_rdata_out <= rdata_d;
	end

	// Field extraction for the running edge. The direction flag picks the nibbles, so
	// the rising and the falling edge can use different shapes and tables.
	assign state_count = edge_length_q[`TES_LEN_COUNT_HI:`TES_LEN_COUNT_LO];
	assign double_time = edge_length_q[`TES_LEN_DOUBLE_BIT];
	// The falling edge takes the upper nibbles, the rising edge the lower ones.
	assign shape_code  = edge_falling_out ? edge_type_q[7:4] : edge_type_q[3:0];
	assign style_code  = edge_falling_out ? edge_style_q[6:4] : edge_style_q[2:0];
	// The register code maps straight onto the amplitude scale, so no multiply is needed.
	assign target_ampl = mod_q ? residual_ampl_q : `TES_AMPL_FULL;

	// Linear progress of the current state; the last state always reaches 0xFF.
	// The divide is combinational: a 13 by 5 bit divide fits one carrier cycle easily
	// and saves a per-count table. It still sees a zero count between edges or after a
	// mid-edge rewrite of the count, so the guard keeps the divider away from a zero divisor.
	assign prog_num  = step_q * 8'hFF;
	assign prog_den  = {8'h00, state_count};
	assign prog_quot = (state_count == 5'h00) ? 13'h00FF : prog_num / prog_den;
	assign prog      = (prog_quot > 13'h00FF) ? 8'hFF : prog_quot[7:0];

	// Shaping: maps linear progress onto the chosen curve, segmented or from a table,
	// with the supply adaptation applied for the adapted table codes.
	tes_curve u_curve (
		.prog_in              (prog),
		.shape_in             (shape_code),
		.style_in             (style_code),
		.pa_supply_voltage_in (pa_supply_voltage_in),
		.frac_out             (frac)
	);

	// Mixing: places the shaped progress between the two levels of the edge, so one
	// curve serves both directions and any pair of levels.
	tes_blend u_blend (
		.start_in (start_q),
		.end_in   (end_q),
		.frac_in  (frac),
		.ampl_out (blend_ampl)
	);

	// The correction step never lets the amplitude move back against the edge,
	// which hides supply bending that would otherwise overshoot near the ends.
	assign keep_monotonic = (shape_code == `TES_SHAPE_LUT_CORR);

	always @* begin
		shaped_ampl = blend_ampl;
		if (keep_monotonic) begin
			if (edge_falling_out && (blend_ampl > carrier_ampl_out))
				shaped_ampl = carrier_ampl_out;
			else if (!edge_falling_out && (blend_ampl < carrier_ampl_out))
				shaped_ampl = carrier_ampl_out;
		end
	end

	// With doubling each state is held for a second carrier cycle; the hold flag
	// alternates, so the state number only advances on every other cycle.
	assign last_hold = !double_time || hold_q;

	// Edge sequencer.
	// A change of the modulation request is taken at the clock edge that sees it and
	// restarts the shaper from the level the carrier has at that moment, even mid-edge,
	// so a short pulse never makes the carrier jump. busy rises at that same edge and the
	// carrier keeps its level for one more cycle while state 1 is being computed.
	// Walk with two states, no doubling, falling from full carrier to zero:
	//   edge 1: the request is seen; busy and the direction are set, step is 1.
	//   edge 2: the carrier takes the level of state 1, about half way; step becomes 2.
	//   edge 3: the carrier reaches the residual level exactly and busy falls.
	// With doubling each level is shown for two cycles, so busy lasts twice as long.
	// With a state count of zero there is no edge at all: the carrier jumps to its target
	// one cycle after the request and busy never rises.
	// Between edges the carrier follows the programmed target live, so a new residual
	// level written while modulating shows at once; software can trim the level that way
	// without toggling the request, at the price of an unshaped step in the carrier.
	always @* begin
		state_d   = state_q;
		mod_d     = mod_q;
		start_d   = start_q;
		end_d     = end_q;
		step_d    = step_q;
		hold_d    = hold_q;
		ampl_d    = carrier_ampl_out;
		busy_d    = edge_busy_out;
		falling_d = edge_falling_out;
		if (modulate_in != mod_q) begin
			// A new request restarts from the level reached, even mid-edge.
			mod_d     = modulate_in;
			start_d   = carrier_ampl_out;
			end_d     = modulate_in ? residual_ampl_q : `TES_AMPL_FULL;
			falling_d = modulate_in;
			step_d    = 5'h01;
			hold_d    = 1'b0;
			if (state_count == 5'h00) begin
				// With no transition states the level jumps at once.
				state_d = ST_IDLE;
				busy_d  = 1'b0;
				ampl_d  = modulate_in ? residual_ampl_q : `TES_AMPL_FULL;
			end else begin
				// State 1 is computed from the captured start level during the next cycle.
				state_d = ST_EDGE;
				busy_d  = 1'b1;
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
					// Between edges the output follows the programmed level.
					ampl_d = target_ampl;
					busy_d = 1'b0;
				end
				ST_EDGE: begin
					// The level of the current state is shown, then the sequencer moves on.
					ampl_d = shaped_ampl;
					if (!last_hold) begin
						hold_d = 1'b1;
					end else begin
						hold_d = 1'b0;
						// A live count lowered below the step ends the edge here.
						if (step_q >= state_count) begin
							state_d = ST_IDLE;
							busy_d  = 1'b0;
						end else begin
							step_d = step_q + 5'h01;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					busy_d  = 1'b0;
				end
			endcase
		end
	end

	// Shaper registers; everything stands still while the clock enable is low.
	// Reset leaves full carrier on the output, the safe level for a reader that has
	// not yet been configured, and no edge pending.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q          <= ST_IDLE;
			mod_q            <= 1'b0;
			start_q          <= `TES_AMPL_FULL;
			end_q            <= `TES_AMPL_FULL;
			step_q           <= 5'h00;
			hold_q           <= 1'b0;
			carrier_ampl_out <= `TES_AMPL_FULL;
			edge_busy_out    <= 1'b0;
			edge_falling_out <= 1'b0;
		end else if (en_in) begin
			state_q          <= state_d;
			mod_q            <= mod_d;
			start_q          <= start_d;
			end_q            <= end_d;
			step_q           <= step_d;
			hold_q           <= hold_d;
			carrier_ampl_out <= ampl_d;
			edge_busy_out    <= busy_d;
			edge_falling_out <= falling_d;
		end
	end
endmodule // tes_top
`default_nettype wire

// [bench/tes_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module tes_top_monitor (
	// Clock and control.
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        en_in,
	// Register port.
	input wire logic [15:0] reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_write_in,
	input wire logic        reg_read_in,
	input wire logic [7:0]  reg_rdata_out,
	// Modulation side.
	input wire logic        modulate_in,
	input wire logic [7:0]  pa_supply_voltage_in,
	input wire logic [7:0]  carrier_ampl_out,
	input wire logic        edge_busy_out,
	input wire logic        edge_falling_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [6:0] busy_cnt_q;
	logic       mod_q;
	// Busy cycles of one edge; a new request restarts the count, as it restarts the edge.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_cnt_q <= 7'h00;
			mod_q      <= 1'b0;
		end else if (en_in) begin
			mod_q      <= modulate_in;
			busy_cnt_q <= (!edge_busy_out || modulate_in != mod_q) ? 7'h00 : busy_cnt_q + 7'h01;
		end
	end
	sequence s_start;
		!edge_busy_out ##1 edge_busy_out;
	endsequence
	sequence s_stop;
		edge_busy_out ##1 !edge_busy_out;
	endsequence
	AST_RDATA_IDLE: assert property (en_in && !reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data not zero outside a read");
	AST_MISALIGNED: assert property (en_in && reg_read_in && reg_addr_in[1:0] != 2'h0 |=> reg_rdata_out == 8'h00)
		else $error("misaligned read returned data");
	AST_IDLE_FULL: assert property ((en_in && !modulate_in && !edge_busy_out) [*3] |-> carrier_ampl_out == 8'hFF)
		else $error("idle unmodulated carrier not full");
	AST_FALL_DIR: assert property (s_start |-> edge_falling_out == $past(modulate_in))
		else $error("edge direction wrong");
	AST_DIR_HOLD: assert property (s_stop |-> $stable(edge_falling_out))
		else $error("direction changed at end of edge");
	AST_START_STEADY: assert property (s_start |-> $stable(carrier_ampl_out))
		else $error("amplitude moved before first state");
	AST_RISE_END: assert property (s_stop ##0 !edge_falling_out |=> carrier_ampl_out == 8'hFF)
		else $error("rising edge did not end at full carrier");
	AST_FREEZE: assert property (!en_in |=> $stable(carrier_ampl_out) && $stable(edge_busy_out))
		else $error("state moved while disabled");
	AST_LEN_BOUND: assert property (busy_cnt_q <= 7'd62)
		else $error("edge longer than 31 doubled states");
endmodule // tes_top_monitor
bind tes_top tes_top_monitor u_mon (.*);
`default_nettype wire

// [bench/tes_field_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tes_field_model (
	// Clock and control.
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       watch_in,
	// Carrier as seen by the antenna.
	input  wire logic [7:0] ampl_in,
	input  wire logic       busy_in,
	input  wire logic       falling_in,
	// Set once a watched falling edge ever went upward.
	output logic            reversed_out
);
	logic [7:0] last_q;
	// A corrected edge must never bounce back; other shapes may, so only watched edges count.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_q       <= 8'hFF;
			reversed_out <= 1'b0;
		end else begin
			last_q <= ampl_in;
			if (watch_in && busy_in && falling_in && ampl_in > last_q) reversed_out <= 1'b1;
		end
	end
endmodule // tes_field_model
`default_nettype wire

// [bench/test_tes_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.vh"
`define TES_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end
module test_tes_top;
	logic        clk_in = 0, rst_n_in = 0, en_in = 1, reg_write_in = 0, reg_read_in = 0, modulate_in = 0, watch = 0;
	logic [15:0] reg_addr_in = 16'h0000;
	logic [7:0]  reg_wdata_in = 8'h00, pa_supply_voltage_in = 8'h80;
	wire  [7:0]  reg_rdata_out, carrier_ampl_out;
	wire         edge_busy_out, edge_falling_out, reversed;
	int          n_fail = 0, samples_checked = 0, cnt, i;
	logic [7:0]  held;
	always #20 clk_in = ~clk_in;
	tes_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(en_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .modulate_in(modulate_in), .pa_supply_voltage_in(pa_supply_voltage_in),
		.carrier_ampl_out(carrier_ampl_out), .edge_busy_out(edge_busy_out), .edge_falling_out(edge_falling_out));
	tes_field_model u_field (.clk_in(clk_in), .rst_n_in(rst_n_in), .watch_in(watch), .ampl_in(carrier_ampl_out),
		.busy_in(edge_busy_out), .falling_in(edge_falling_out), .reversed_out(reversed));
	// Report and stop; every path that ends the run comes through here.
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wr(input logic [13:0] idx, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in  <= {idx, 2'b00};
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clk_in);
		reg_write_in <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task rd(input logic [15:0] addr, input logic [7:0] exp);
		@(posedge clk_in);
		reg_addr_in <= addr;
		reg_read_in <= 1'b1;
		@(posedge clk_in);
		reg_read_in <= 1'b0;
		#1 `TES_CHK(reg_rdata_out, exp)
	endtask
	// Request one edge, count its busy cycles and check where the carrier lands.
	task edge_run(input logic v, input int n_exp, input logic [7:0] a_exp);
		@(posedge clk_in);
		modulate_in <= v;
		cnt = 0;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_in);
			#1;
			if (edge_busy_out !== 1'b1) break;
			cnt++;
		end
		if (i == 100) begin n_fail++; wrap_up; end
		`TES_CHK(cnt, n_exp)
		`TES_CHK(carrier_ampl_out, a_exp)
		`TES_CHK(edge_falling_out, v)
	endtask
	task t_regs;
		rd({`TES_IDX_EDGE_LENGTH, 2'b00}, `TES_RST_EDGE_LENGTH);
		rd({`TES_IDX_EDGE_TYPE, 2'b00}, `TES_RST_EDGE_TYPE);
		rd({`TES_IDX_RESIDUAL_AMPL, 2'b00}, `TES_RST_RESIDUAL_AMPL);
		rd({`TES_IDX_EDGE_STYLE, 2'b00}, `TES_RST_EDGE_STYLE);
		wr(`TES_IDX_EDGE_LENGTH, 8'hFF);
		wr(`TES_IDX_EDGE_STYLE, 8'hFF);
		wr(`TES_IDX_EDGE_TYPE, 8'hA5);
		rd({`TES_IDX_EDGE_LENGTH, 2'b00}, 8'h9F);
		rd({`TES_IDX_EDGE_STYLE, 2'b00}, 8'h77);
		rd({`TES_IDX_EDGE_TYPE, 2'b00}, 8'hA5);
		rd(16'h1480, 8'h00);
		rd(16'h144D, 8'h00);
	endtask
	// Shortest and longest state counts, with and without doubling.
	task t_length;
		wr(`TES_IDX_RESIDUAL_AMPL, 8'h40);
		wr(`TES_IDX_EDGE_TYPE, 8'h11);
		for (int d = 0; d < 2; d++) begin
			for (int n = 1; n < 32; n += 30) begin
				wr(`TES_IDX_EDGE_LENGTH, {d[0], 2'b00, n[4:0]});
				edge_run(1'b1, n * (d + 1), 8'h40);
				edge_run(1'b0, n * (d + 1), 8'hFF);
			end
		end
	endtask
	// Status first: after the doubled 31-state rising edge it shows idle, rising, unmodulated, state 31.
	task t_zero;
		rd({`TES_IDX_STATUS, 2'b00}, 8'h1F);
		wr(`TES_IDX_EDGE_LENGTH, 8'h80);
		wr(`TES_IDX_RESIDUAL_AMPL, 8'h80);
		edge_run(1'b1, 0, 8'h80);
		edge_run(1'b0, 0, 8'hFF);
	endtask
	// Every shape code on both nibbles, with table numbers cycling through all four.
	task t_codes;
		wr(`TES_IDX_EDGE_LENGTH, 8'h04);
		wr(`TES_IDX_RESIDUAL_AMPL, 8'h00);
		pa_supply_voltage_in <= 8'hFF;
		for (int c = 1; c < 7; c++) begin
			wr(`TES_IDX_EDGE_TYPE, {c[3:0], 4'h7 - c[3:0]});
			wr(`TES_IDX_EDGE_STYLE, {1'b0, c[2:0] & 3'h3, 1'b0, 3'h3 - (c[2:0] & 3'h3)});
			watch <= (c == 5);
			edge_run(1'b1, 4, 8'h00);
			edge_run(1'b0, 4, 8'hFF);
		end
		`TES_CHK(reversed, 1'b0)
		pa_supply_voltage_in <= 8'h80;
		wr(`TES_IDX_RESIDUAL_AMPL, 8'hFF);
		edge_run(1'b1, 4, 8'hFF);
		edge_run(1'b0, 4, 8'hFF);
	endtask
	// Clock enable low in mid-edge must hold the carrier where it is.
	task t_freeze;
		wr(`TES_IDX_EDGE_LENGTH, 8'h08);
		wr(`TES_IDX_RESIDUAL_AMPL, 8'h00);
		@(posedge clk_in);
		modulate_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		en_in <= 1'b0;
		#1 held = carrier_ampl_out;
		repeat (4) @(posedge clk_in);
		#1 `TES_CHK(carrier_ampl_out, held)
		`TES_CHK(edge_busy_out, 1'b1)
		@(posedge clk_in);
		en_in <= 1'b1;
		edge_run(1'b0, 8, 8'hFF);
	endtask
	initial begin
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_regs;
		t_length;
		t_zero;
		t_codes;
		t_freeze;
		wrap_up;
	end
endmodule // test_tes_top
`default_nettype wire
